// >>> hw/fc_test_traffic_injector.sv
/*
 * fibre channel test-traffic generator and checker: frame builder,
 * payload pattern generator, alarm and error insertion, tx frequency
 * offset word and receive status.
 * assumes a serdes outside that takes 32-bit words with k flags, does
 * the line coding, turns tx_ppm into a frequency trim, and hands back
 * received words plus raw signal-detect and word-lock levels.
 */

module fc_test_traffic_injector #(
    parameter int CYC_PER_1S = fc_tti_pkg::CYC_1S,
    parameter int CYC_PER_10S = fc_tti_pkg::CYC_10S
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire fc_tti_pkg::port_mode_e port_mode,
    input wire fc_tti_pkg::framing_e framing,
    input wire fc_tti_pkg::pattern_e pattern,
    input wire logic [31:0] user_word,
    input wire logic [fc_tti_pkg::LEN_W-1:0] payload_len,
    input wire logic [7:0] r_ctl,
    input wire logic [23:0] d_id,
    input wire logic [7:0] cs_ctl,
    input wire logic [23:0] s_id,
    input wire logic [7:0] fc_type,
    input wire logic [23:0] f_ctl,
    input wire logic [7:0] seq_id,
    input wire logic [7:0] df_ctl,
    input wire logic [15:0] ox_id,
    input wire logic [15:0] rx_id,
    input wire logic [31:0] parm,
    input wire logic gen_enable,
    input wire fc_tti_pkg::alarm_e alarm_sel,
    input wire fc_tti_pkg::err_e err_sel,
    input wire fc_tti_pkg::ins_e ins_mode,
    input wire logic [fc_tti_pkg::BURST_W-1:0] burst_len,
    input wire logic err_trigger,
    input wire logic signed [fc_tti_pkg::PPM_W-1:0] tx_deviation,
    input wire logic meas_start,
    input wire logic signed [fc_tti_pkg::PPM_W-1:0] rx_ppm_meas,
    input wire logic [31:0] rx_rate_meas,
    input wire logic rx_sig_det,
    input wire logic rx_word_lock,
    input wire logic [31:0] rx_word,
    input wire logic rx_word_valid,
    input wire logic rx_is_payload,
    output logic [31:0] tx_word,
    output logic [3:0] tx_kflag,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic tx_64b66b,
    output logic signed [fc_tti_pkg::PPM_W-1:0] tx_ppm,
    output logic signal_present,
    output logic sync_acquired,
    output logic [31:0] rx_rate,
    output logic signed [fc_tti_pkg::PPM_W-1:0] rx_ppm,
    output logic signed [fc_tti_pkg::ACC_W-1:0] acc_diff,
    output logic traffic_detected,
    output logic pattern_sync,
    output logic pattern_error
);
    import fc_tti_pkg::*;
    typedef enum logic [2:0] {
        F_IDLE, F_SOF, F_HDR, F_DATA, F_CRC, F_EOF
    } fstate_e;

    typedef struct packed {
        fstate_e fs;
        logic [2:0] hidx;
        logic [LEN_W-1:0] left;
        logic [31:0] crc;
        logic [30:0] prbs;
        logic [5:0] fox;
        logic [15:0] seq_cnt;
        logic [BURST_W-1:0] pend;
        logic [31:0] tick;
        logic [23:0] lfsr;
        logic trig_d;
        logic [2:0] sd_s;
        logic [2:0] wl_s;
        logic [30:0] chk;
        logic [3:0] good;
        logic [15:0] quiet;
        logic [31:0] otx_w;
        logic [3:0] otx_k;
        logic [PPM_W-1:0] oppm;
        logic o64;
        logic osp;
        logic osy;
        logic [31:0] orate;
        logic [PPM_W-1:0] orppm;
        logic [ACC_W-1:0] oacc;
        logic otraf;
        logic opsync;
        logic operr;
    } state_s;

    state_s q, d;

    logic [35:0] f_in, f_out;
    logic f_in_valid, f_in_ready;

    function automatic logic [7:0] fox_char(input logic [5:0] i);
        localparam string S =
            "The quick brown fox jumped over the lazy dog 1234567890";
        fox_char = S[i];
    endfunction : fox_char

    function automatic logic [31:0] crc_word(input logic [31:0] c,
                                             input logic [31:0] w);
        logic [31:0] r;
        r = c;
        for (int b = 31; b >= 0; b--) begin
            r = {r[30:0], 1'b0} ^ ((r[31] ^ w[b]) ? CRC_POLY : 32'h0);
        end
        crc_word = r;
    endfunction : crc_word

    // one 32-bit step of the chosen sequence; also used by the checker
    function automatic logic [30:0] prbs_step(input logic [30:0] s,
                                              input pattern_e p);
        logic [30:0] r;
        r = s;
        for (int b = 0; b < 32; b++) begin
            case (p)
                PAT_PRBS9: r = {r[29:0], r[8] ^ r[4]};
                PAT_PRBS15: r = {r[29:0], r[14] ^ r[13]};
                PAT_PRBS23: r = {r[29:0], r[22] ^ r[17]};
                default: r = {r[29:0], r[30] ^ r[27]};
            endcase
        end
        prbs_step = r;
    endfunction : prbs_step

    function automatic logic [23:0] rate_mask(input ins_e m);
        case (m)
            INS_E2: rate_mask = 24'h00007f;
            INS_E3: rate_mask = 24'h0003ff;
            INS_E4: rate_mask = 24'h001fff;
            INS_E5: rate_mask = 24'h01ffff;
            INS_E6: rate_mask = 24'h0fffff;
            default: rate_mask = 24'hffffff;
        endcase
    endfunction : rate_mask

    logic is64;
    logic [31:0] pay;
    logic [31:0] hdr;
    logic [31:0] w;
    logic [3:0] k;
    logic take;
    logic tx_valid_w;
    logic ostg_load;
    // output stage loads only when empty or drained, so no word is lost
    assign ostg_load = !tx_valid || tx_ready;
    logic fire;
    logic hit;
    logic [30:0] chk_next;

    always_comb begin
        d = q;
        is64 = (port_mode == PM_10G) || (port_mode == PM_16G);
        w = OS_IDLE;
        k = K_FIRST;
        take = f_in_ready && gen_enable && port_mode != PM_OFF;
        fire = 1'b0;
        hit = 1'b0;
        chk_next = prbs_step(q.chk, pattern);

        case (pattern)
            PAT_ALT: pay = ALT_WORD;
            PAT_USER: pay = user_word;
            PAT_ZERO: pay = 32'h0;
            default: pay = {q.prbs, 1'b0};
        endcase
        if (pattern == PAT_FOX) begin
            pay = {fox_char(q.fox), fox_char(6'(q.fox + 6'd1)),
                   fox_char(6'(q.fox + 6'd2)), fox_char(6'(q.fox + 6'd3))};
        end

        case (q.hidx)
            3'd0: hdr = {r_ctl, d_id};
            3'd1: hdr = {cs_ctl, s_id};
            3'd2: hdr = {fc_type, f_ctl};
            3'd3: hdr = {seq_id, df_ctl, q.seq_cnt};
            3'd4: hdr = {ox_id, rx_id};
            default: hdr = parm;
        endcase

        // error scheduler
        d.trig_d = err_trigger;
        d.lfsr = {q.lfsr[22:0], q.lfsr[23] ^ q.lfsr[22] ^ q.lfsr[21]
                  ^ q.lfsr[16]};
        if (q.lfsr == 24'h0) begin
            d.lfsr = 24'h000001;
        end
        d.tick = q.tick + 32'd1;
        case (ins_mode)
            INS_OFF: d.pend = '0;
            INS_MANUAL: fire = err_trigger && !q.trig_d;
            INS_1S: fire = (q.tick >= 32'(CYC_PER_1S - 1));
            INS_10S: fire = (q.tick >= 32'(CYC_PER_10S - 1));
            default: fire = take && ((q.lfsr & rate_mask(ins_mode))
                                     == 24'h0);
        endcase
        if (fire || ins_mode == INS_OFF || ins_mode == INS_MANUAL) begin
            d.tick = '0;
        end
        if (fire && ins_mode != INS_OFF) begin
            d.pend = burst_len;
        end

        if (alarm_sel != ALM_NONE) begin
            case (alarm_sel)
                ALM_LR: w = OS_LR;
                ALM_LRR: w = OS_LRR;
                ALM_NOS: w = OS_NOS;
                default: w = OS_OLS;
            endcase
            d.fs = F_IDLE;
        end else if (q.pend != '0 && err_sel == ERR_RRDY
                     && q.fs == F_IDLE) begin
            w = OS_RRDY;
            hit = 1'b1;
        end else begin
            case (q.fs)
                F_IDLE: begin
                    if (take) begin
                        d.fs = F_SOF;
                    end
                end
                F_SOF: begin
                    w = OS_SOF;
                    d.crc = 32'hffffffff;
                    d.hidx = '0;
                    d.left = (payload_len > MAX_PAYLOAD) ? MAX_PAYLOAD
                             : payload_len;
                    if (take) begin
                        d.fs = (framing == FRM_HEADER) ? F_HDR : F_DATA;
                        if (framing != FRM_HEADER && d.left == '0) begin
                            d.fs = F_EOF;
                        end
                    end
                end
                F_HDR: begin
                    w = hdr;
                    k = 4'h0;
                    if (take) begin
                        d.crc = crc_word(q.crc, w);
                        d.hidx = q.hidx + 3'd1;
                        if (q.hidx == 3'(HDR_WORDS - 1)) begin
                            d.fs = (q.left == '0) ? F_CRC : F_DATA;
                        end
                    end
                end
                F_DATA: begin
                    w = pay;
                    k = 4'h0;
                    if (q.pend != '0 && err_sel == ERR_BIT) begin
                        w[0] = ~w[0];
                        hit = 1'b1;
                    end
                    if (take) begin
                        d.crc = crc_word(q.crc, pay);
                        d.prbs = prbs_step(q.prbs, pattern);
                        d.fox = (q.fox >= 6'(FOX_LEN - 4))
                                ? 6'(q.fox + 6'd4 - 6'(FOX_LEN))
                                : q.fox + 6'd4;
                        d.left = (q.left > 12'd4) ? q.left - 12'd4 : '0;
                        if (q.left <= 12'd4) begin
                            d.fs = (framing == FRM_HEADER) ? F_CRC
                                   : F_EOF;
                        end
                    end
                end
                F_CRC: begin
                    w = ~q.crc;
                    k = 4'h0;
                    if (q.pend != '0 && err_sel == ERR_CRC
                        && framing == FRM_HEADER) begin
                        w[0] = ~w[0];
                        hit = 1'b1;
                    end
                    if (take) begin
                        d.fs = F_EOF;
                    end
                end
                default: begin
                    w = OS_EOF;
                    if (take) begin
                        d.fs = F_IDLE;
                        d.seq_cnt = q.seq_cnt + 16'd1;
                    end
                end
            endcase
            if (q.pend != '0 && err_sel == ERR_SYMBOL && !is64
                && q.fs == F_DATA) begin
                k = K_BADSYM;
                hit = 1'b1;
            end
            if (q.pend != '0 && err_sel == ERR_BLOCK && is64
                && q.fs == F_DATA) begin
                w = ~w;
                hit = 1'b1;
            end
        end
        f_in = {k, w};
        f_in_valid = take;
        if (hit && take && ins_mode != INS_OFF && !fire) begin
            d.pend = q.pend - 1'b1;
        end
        if (q.prbs == '0) begin
            d.prbs = 31'h7fffffff;
        end

        // outputs and receive status
        if (ostg_load) begin
            {d.otx_k, d.otx_w} = f_out;
        end
        d.oppm = tx_deviation;
        d.o64 = is64;
        d.sd_s = {q.sd_s[1:0], rx_sig_det};
        d.wl_s = {q.wl_s[1:0], rx_word_lock};
        if (q.sd_s[2] == q.sd_s[1]) begin
            d.osp = q.sd_s[2];
        end
        if (q.wl_s[2] == q.wl_s[1]) begin
            d.osy = q.wl_s[2];
        end
        d.orate = rx_rate_meas;
        d.orppm = rx_ppm_meas;
        d.oacc = meas_start ? '0
                 : q.oacc + ACC_W'(signed'(rx_ppm_meas));

        // receive checker shares the generator's pattern choice
        if (rx_word_valid && rx_is_payload) begin
            d.otraf = 1'b1;
            d.quiet = '0;
            if (pattern inside {PAT_PRBS9, PAT_PRBS15, PAT_PRBS23,
                                PAT_PRBS31}) begin
                d.chk = rx_word[31:1];
                if (rx_word == {chk_next, 1'b0}) begin
                    d.good = (q.good == 4'hf) ? q.good : q.good + 4'd1;
                end else begin
                    d.good = '0;
                end
            end else begin
                case (pattern)
                    PAT_ALT: d.good = (rx_word == ALT_WORD) ? 4'hf : '0;
                    PAT_ZERO: d.good = (rx_word == '0) ? 4'hf : '0;
                    PAT_USER: d.good = (rx_word == user_word) ? 4'hf : '0;
                    default: d.good = 4'hf;
                endcase
            end
            d.operr = q.opsync && (d.good == '0);
            d.opsync = (d.good >= 4'd4);
        end else begin
            d.operr = 1'b0;
            d.quiet = (q.quiet == 16'hffff) ? q.quiet : q.quiet + 16'd1;
            if (q.quiet == 16'hfffe) begin
                d.otraf = 1'b0;
                d.opsync = 1'b0;
            end
        end
    end

    fc_tti_fifo #(
        .WIDTH(36),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .in_data(f_in),
        .in_valid(f_in_valid),
        .in_ready(f_in_ready),
        .out_data(f_out),
        .out_valid(tx_valid_w),
        .out_ready(ostg_load)
    );

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
            tx_valid <= 1'b0;
        end else if (ce) begin
            q <= d;
            if (ostg_load) begin
                tx_valid <= tx_valid_w;
            end
        end
    end

    assign tx_word = q.otx_w;
    assign tx_kflag = q.otx_k;
    assign tx_64b66b = q.o64;
    assign tx_ppm = q.oppm;
    assign signal_present = q.osp;
    assign sync_acquired = q.osy;
    assign rx_rate = q.orate;
    assign rx_ppm = q.orppm;
    assign acc_diff = q.oacc;
    assign traffic_detected = q.otraf;
    assign pattern_sync = q.opsync;
    assign pattern_error = q.operr;
endmodule : fc_test_traffic_injector

// >>> hw/fc_tti_fifo.sv
/*
 * synchronous flip-flop FIFO with valid/ready on both sides.
 * assumes one clock, active-low async reset and a freezing clock enable.
 */
module fc_tti_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q, rp_q;
    logic [AW:0] cnt_q;
    logic push, pop;

    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rp_q];
    assign push = in_valid && in_ready && ce;
    assign pop = out_valid && out_ready && ce;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

    // storage carries no reset: empty entries still reach the output stage, but only while tx_valid is loaded low
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end
endmodule : fc_tti_fifo

// >>> hw/fc_tti_pkg.sv
/*
 * constants, enumerations and timing counts for the fibre channel
 * test-traffic injector.
 * assumes a single 125 MHz clock; the transmit side works on 32-bit
 * transmission words with a per-byte control (k-character) flag.
 */
package fc_tti_pkg;
    localparam int CLK_HZ = 125000000;
    localparam int WORD_W = 32;
    localparam int KFLAG_W = 4;
    localparam int FIFO_DEPTH = 8;
    localparam int LEN_W = 12;
    localparam logic [LEN_W-1:0] MAX_PAYLOAD = 12'd2112;
    localparam int HDR_WORDS = 6;
    localparam int BURST_W = 8;
    localparam int PERIOD_1S_MS = 1000;
    localparam int PERIOD_10S_MS = 10000;
    localparam int CYC_1S = CLK_HZ / 1000 * PERIOD_1S_MS;
    localparam int CYC_10S = CLK_HZ / 1000 * PERIOD_10S_MS;
    localparam int PPM_W = 16;
    localparam int ACC_W = 32;

    // 8b/10b byte codes of the ordered sets
    localparam logic [7:0] K28_5 = 8'hbc;
    localparam logic [7:0] D9_2 = 8'h49;
    localparam logic [7:0] D31_5 = 8'hbf;
    localparam logic [7:0] D21_1 = 8'h35;
    localparam logic [7:0] D21_2 = 8'h55;
    localparam logic [7:0] D5_2 = 8'h45;
    localparam logic [7:0] D10_4 = 8'h8a;
    localparam logic [7:0] D21_4 = 8'h95;
    localparam logic [7:0] D10_2 = 8'h4a;
    localparam logic [31:0] OS_LR = {K28_5, D9_2, D31_5, D9_2};
    localparam logic [31:0] OS_LRR = {K28_5, D21_1, D31_5, D9_2};
    localparam logic [31:0] OS_NOS = {K28_5, D21_2, D31_5, D5_2};
    localparam logic [31:0] OS_OLS = {K28_5, D21_1, D10_4, D21_2};
    localparam logic [31:0] OS_RRDY = {K28_5, D21_4, D10_2, D10_2};
    localparam logic [31:0] OS_IDLE = {K28_5, 8'h95, 8'hb5, 8'hb5};
    localparam logic [31:0] OS_SOF = {K28_5, 8'hb5, 8'h36, 8'h36};
    localparam logic [31:0] OS_EOF = {K28_5, 8'h95, 8'hd5, 8'hd5};
    localparam logic [3:0] K_FIRST = 4'h8;
    // marker that the symbol-error path replaces with an invalid 10b code
    localparam logic [3:0] K_BADSYM = 4'hf;
    localparam logic [31:0] CRC_POLY = 32'h04c11db7;
    localparam logic [31:0] ALT_WORD = 32'h55555555;
    localparam int FOX_LEN = 55;

    typedef enum logic [3:0] {
        PAT_FOX, PAT_ALT, PAT_PRBS9, PAT_PRBS15, PAT_PRBS23,
        PAT_PRBS31, PAT_USER, PAT_ZERO
    } pattern_e;
    typedef enum logic [1:0] {FRM_PLAIN, FRM_HEADER} framing_e;
    typedef enum logic [2:0] {
        ALM_NONE, ALM_LR, ALM_LRR, ALM_NOS, ALM_OLS
    } alarm_e;
    typedef enum logic [2:0] {
        ERR_NONE, ERR_BIT, ERR_SYMBOL, ERR_RRDY, ERR_CRC, ERR_BLOCK
    } err_e;
    typedef enum logic [3:0] {
        INS_OFF, INS_MANUAL, INS_1S, INS_10S, INS_E2, INS_E3, INS_E4,
        INS_E5, INS_E6, INS_E7
    } ins_e;
    typedef enum logic [2:0] {
        PM_OFF, PM_1G, PM_2G, PM_4G, PM_8G, PM_10G, PM_16G
    } port_mode_e;
endpackage : fc_tti_pkg

// >>> verification/fc_test_traffic_injector_tb.sv
/* self-checking bench of the traffic injector with a looping far end.
 * assumes the design package and the checker are compiled first. */
module fc_test_traffic_injector_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fc_tti_pkg::*;
    logic clk = 0, resetn = 0, ce = 1, slow = 0, hit = 0;
    port_mode_e port_mode = PM_8G;
    framing_e framing = FRM_PLAIN;
    pattern_e pattern = PAT_ZERO;
    logic [31:0] user_word = 32'hc3a5f00f, parm = 32'h0badcafe;
    logic [11:0] payload_len = 12'h008;
    logic [7:0] r_ctl = 8'h00, cs_ctl = 8'h11, fc_type = 8'he0;
    logic [7:0] seq_id = 8'h5a, df_ctl = 8'h02, burst_len = 8'h02;
    logic [23:0] d_id = 24'h010203, s_id = 24'h040506, f_ctl = 24'h290000;
    logic [15:0] ox_id = 16'h1234, rx_id = 16'hfedc;
    logic gen_enable = 0, err_trigger = 0, meas_start = 0;
    logic rx_sig_det = 0, rx_word_lock = 0;
    alarm_e alarm_sel = ALM_NONE;
    err_e err_sel = ERR_NONE;
    ins_e ins_mode = INS_OFF;
    logic signed [15:0] tx_deviation = 16'sh0, rx_ppm_meas = 16'sh0007;
    logic [31:0] rx_rate_meas = 32'h1fd32800, tx_word, rx_word, rx_rate;
    logic [3:0] tx_kflag;
    logic tx_valid, tx_ready, tx_64b66b, rx_word_valid, rx_is_payload;
    logic signed [15:0] tx_ppm, rx_ppm;
    logic signed [31:0] acc_diff;
    logic signal_present, sync_acquired, traffic_detected;
    logic pattern_sync, pattern_error;
    int err_total = 0, compares = 0;
    logic [31:0] fr[$];
    alarm_e al[4] = '{ALM_LR, ALM_LRR, ALM_NOS, ALM_OLS};
    logic [31:0] os[4] = '{OS_LR, OS_LRR, OS_NOS, OS_OLS};
    fc_test_traffic_injector #(.CYC_PER_1S(100), .CYC_PER_10S(1000)) DUT (.*);
    fc_tti_partner far_end (.*);
    initial forever #4 clk = ~clk;
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic check(input string what, input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic tally_and_finish;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : tally_and_finish
    function automatic int seen_n(input logic [31:0] w);
        seen_n = 0;
        foreach (far_end.got[i]) if (far_end.got[i][31:0] === w) seen_n++;
    endfunction : seen_n
    // skip words queued under the old settings, then keep one whole frame
    task automatic grab;
        bit on = 0;
        fr.delete();
        cyc(40);
        far_end.got.delete();
        cyc(160);
        foreach (far_end.got[i]) begin
            if (far_end.got[i][31:0] === OS_SOF) on = 1;
            if (on && fr.size() < 40) fr.push_back(far_end.got[i][31:0]);
            if (on && far_end.got[i][31:0] === OS_EOF) break;
        end
    endtask : grab
    task automatic burst(input err_e e, input ins_e m, input int n);
        err_sel <= e;
        ins_mode <= m;
        cyc(40);
        far_end.got.delete();
        err_trigger <= 1;
        cyc(1);
        err_trigger <= 0;
        cyc(n);
    endtask : burst
    initial begin
        cyc(2);
        resetn <= 1;
        cyc(1);
        check("tx_valid after reset", tx_valid, 0);
        gen_enable <= 1;
        grab;
        check("plain length", fr.size(), 4);
        check("zero payload", fr[1] | fr[2], 0);
        payload_len <= 12'h000;
        grab;
        check("empty frame", fr.size(), 2);
        payload_len <= 12'h004;
        pattern <= PAT_USER;
        grab;
        check("user word", fr[1], user_word);
        pattern <= PAT_ALT;
        grab;
        check("alternating word", fr[1], 32'h55555555);
        framing <= FRM_HEADER;
        pattern <= PAT_USER;
        slow <= 1;
        grab;
        slow <= 0;
        check("header length", fr.size(), 10);
        check("hdr 0", fr[1], {r_ctl, d_id});
        check("hdr 1", fr[2], {cs_ctl, s_id});
        check("hdr 2", fr[3], {fc_type, f_ctl});
        check("hdr 3", fr[4][31:16], {seq_id, df_ctl});
        check("hdr 4", fr[5], {ox_id, rx_id});
        check("hdr 5", fr[6], parm);
        check("hdr data", fr[7], user_word);
        foreach (al[i]) begin
            alarm_sel <= al[i];
            cyc(40);
            far_end.got.delete();
            cyc(30);
            check("alarm flowing", far_end.got.size() > 20, 1);
            check("alarm only", seen_n(os[i]), far_end.got.size());
        end
        alarm_sel <= ALM_NONE;
        grab;
        check("frames resume", fr.size(), 10);
        framing <= FRM_PLAIN;
        pattern <= PAT_ZERO;
        payload_len <= 12'h040;
        burst(ERR_BIT, INS_MANUAL, 200);
        check("manual bit errors", seen_n(32'h1), burst_len);
        burst(ERR_BIT, INS_OFF, 200);
        check("off inserts none", seen_n(32'h1), 0);
        burst_len <= 8'h01;
        burst(ERR_RRDY, INS_MANUAL, 200);
        check("one rrdy", seen_n(OS_RRDY), 1);
        burst(ERR_RRDY, INS_1S, 1000);
        check("rrdy per period", seen_n(OS_RRDY), 10);
        burst(ERR_RRDY, INS_E2, 2000);
        check("rate inserts", seen_n(OS_RRDY) inside {[2:60]}, 1);
        ins_mode <= INS_OFF;
        tx_deviation <= 16'sh0032;
        rx_sig_det <= 1;
        meas_start <= 1;
        pattern <= PAT_PRBS9;
        cyc(300);
        check("tx ppm", tx_ppm, 16'h0032);
        check("signal present", signal_present, 1);
        check("no word sync", sync_acquired, 0);
        check("acc cleared", acc_diff, 0);
        check("rx rate", rx_rate, rx_rate_meas);
        check("rx ppm", rx_ppm, 32'h7);
        check("traffic", traffic_detected, 1);
        check("pattern sync", pattern_sync, 1);
        meas_start <= 0;
        rx_word_lock <= 1;
        burst(ERR_BIT, INS_MANUAL, 0);
        repeat (200) @(negedge clk) hit |= pattern_error;
        check("pattern error", hit, 1);
        check("word sync", sync_acquired, 1);
        check("acc running", acc_diff != 0, 1);
        port_mode <= PM_10G;
        burst(ERR_SYMBOL, INS_MANUAL, 20);
        check("64b66b flag", tx_64b66b, 1);
        tally_and_finish;
    end
    initial begin
        #400us;
        err_total++;
        tally_and_finish;
    end
endmodule : fc_test_traffic_injector_tb
bind fc_test_traffic_injector fc_tti_assertions chk (.*);

// >>> verification/fc_tti_assertions.sv
/* port-level checks of the injector: alarm sets, tx trim, line code,
 * receive status and measurement clear.
 * assumes a bind into the injector with ports matched by name. */
module fc_tti_assertions (
    input wire logic clk,
    input wire logic resetn,
    input wire fc_tti_pkg::alarm_e alarm_sel,
    input wire fc_tti_pkg::port_mode_e port_mode,
    input wire logic signed [fc_tti_pkg::PPM_W-1:0] tx_deviation,
    input wire logic meas_start,
    input wire logic rx_sig_det,
    input wire logic rx_word_lock,
    input wire logic [31:0] tx_word,
    input wire logic [3:0] tx_kflag,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic tx_64b66b,
    input wire logic signed [fc_tti_pkg::PPM_W-1:0] tx_ppm,
    input wire logic signal_present,
    input wire logic sync_acquired,
    input wire logic signed [fc_tti_pkg::ACC_W-1:0] acc_diff
);
    import fc_tti_pkg::*;
    // twelve accepted words flush old traffic out of fifo and output stage
    logic [3:0] hs_q;
    alarm_e al_q;
    logic ok;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hs_q <= 4'h0;
            al_q <= ALM_NONE;
        end else begin
            al_q <= alarm_sel;
            if (alarm_sel != al_q) hs_q <= 4'h0;
            else if (tx_valid && tx_ready && hs_q != 4'hf) hs_q <= hs_q + 4'h1;
        end
    end
    assign ok = hs_q > 4'hb && alarm_sel == al_q && tx_valid;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    lr_set_a: assert property (
        ok && alarm_sel == ALM_LR |-> tx_word == OS_LR) else $error("lr");
    lrr_set_a: assert property (
        ok && alarm_sel == ALM_LRR |-> tx_word == OS_LRR) else $error("lrr");
    nos_set_a: assert property (
        ok && alarm_sel == ALM_NOS |-> tx_word == OS_NOS) else $error("nos");
    ols_set_a: assert property (
        ok && alarm_sel == ALM_OLS |-> tx_word == OS_OLS) else $error("ols");
    alarm_kflag_a: assert property (
        ok && alarm_sel != ALM_NONE |-> tx_kflag == K_FIRST) else $error("k");
    tx_trim_a: assert property (
        $stable(tx_deviation)[*4] |-> tx_ppm == tx_deviation) else $error("t");
    line_code_a: assert property (
        $stable(port_mode)[*4] |-> tx_64b66b == (port_mode inside {PM_10G,
        PM_16G})) else $error("line code flag wrong");
    no_badsym_a: assert property (
        tx_64b66b && tx_valid |-> tx_kflag != K_BADSYM) else $error("sym");
    sig_status_a: assert property (
        $stable(rx_sig_det)[*8] |-> signal_present == rx_sig_det)
        else $error("signal present wrong");
    sync_status_a: assert property (
        $stable(rx_word_lock)[*8] |-> sync_acquired == rx_word_lock)
        else $error("sync acquired wrong");
    acc_clear_a: assert property (
        meas_start[*2] |-> acc_diff == 0) else $error("acc not cleared");
endmodule : fc_tti_assertions

// >>> verification/fc_tti_partner.sv
/* far-end port model: sinks tx words, stalling when slow, logs them and
 * loops each accepted word back as a received word.
 * assumes the injector's tx and rx ports on the same clock. */
module fc_tti_partner (
    input wire logic clk,
    input wire logic resetn,
    input wire logic slow,
    input wire logic [31:0] tx_word,
    input wire logic [3:0] tx_kflag,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic [31:0] rx_word,
    output logic rx_word_valid,
    output logic rx_is_payload
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [35:0] got[$];
    logic [1:0] ph = 2'h0;
    wire take = tx_valid && tx_ready;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tx_ready <= 1'b0;
            rx_word_valid <= 1'b0;
            rx_word <= 32'h0;
            rx_is_payload <= 1'b0;
        end else begin
            ph <= ph + 2'h1;
            tx_ready <= !slow || ph == 2'h3;
            rx_word_valid <= take;
            // an idle line never repeats the last word
            rx_word <= take ? tx_word : ~rx_word;
            rx_is_payload <= take && tx_kflag == 4'h0;
            if (take) got.push_back({tx_kflag, tx_word});
        end
    end
endmodule : fc_tti_partner
